// ===== verification/ccl_analog_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Analog cores: two cores on four shared inverting pins, each against one of two references (15 or 25).
module ccl_analog_model (
  input wire logic [1:0] enable_in,
  input wire logic [3:0] channel_in,
  input wire logic [1:0] ref_in,
  output logic [1:0] lt_out
);
  int ain [4] = '{0, 10, 20, 30};
  // Input pins are taken as analog with drivers off. A core that is off is
  // powered down and its output is junk, shown as 1 so that masking is tested.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lt_out[i] = enable_in[i] && ain[channel_in[i*2+:2]] < (ref_in[i] ? 25 : 15);
      if (!enable_in[i]) lt_out[i] = 1'b1;
    end
  end
endmodule : ccl_analog_model

// ===== verification/ccl_top_asserts.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checks; one clock domain, so clocking and reset are given once.
module ccl_top_asserts (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] port_latch_in,
  input wire logic [1:0] cmp_enable_out,
  input wire logic [1:0] cmp_pin_override_out,
  input wire logic [1:0] cmp_pin_data_out,
  input wire logic [1:0] cmp_pin_drive_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // Drive lags its control bits by one register, so the previous cycle also counts.
  property p_drive_en;
    (cmp_pin_drive_out & ~(cmp_enable_out | $past(cmp_enable_out))) == 2'b00;
  endproperty
  a_drive_en: assert property (p_drive_en) else $error("pin driven while disabled");
  property p_drive_oe;
    (cmp_pin_drive_out & ~(cmp_pin_override_out | $past(cmp_pin_override_out))) == 2'b00;
  endproperty
  a_drive_oe: assert property (p_drive_oe) else $error("pin driven without enable");
  property p_latch_pass;
    ((cmp_pin_data_out ^ $past(port_latch_in, 3)) & ~cmp_pin_override_out
      & ~$past(cmp_pin_override_out)) == 2'b00;
  endproperty
  a_latch_pass: assert property (p_latch_pass) else $error("port latch not passed");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule : ccl_top_asserts

bind ccl_top ccl_top_asserts chk_u (.clk_sys_in, .arst_n_in, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_latch_in, .cmp_enable_out,
  .cmp_pin_override_out, .cmp_pin_data_out, .cmp_pin_drive_out);

// ===== verification/test_comparator_control_logic.sv
`timescale 1ns/100ps
// ==========================================================================
// Register-level bench for the comparator control block.
module test_comparator_control_logic;
  localparam logic [1:0] OK = ccl_pkg::CCL_RESP_OKAY;
  localparam logic [1:0] ERR = ccl_pkg::CCL_RESP_SLVERR;
  localparam logic [3:0] AX = ccl_pkg::CCL_ADDR_SECOND_AUX;
  logic clk_sys_in, arst_n_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cmp_channel_sel_out, ca;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmp_lt_in, pin_direction_in, port_latch_in;
  logic [1:0] cmp_enable_out, cmp_ref_sel_out, cmp_pin_override_out, cmp_pin_data_out;
  logic [1:0] cmp_pin_drive_out;
  logic [7:0] ctl;
  logic res;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  ccl_top dut_u (.clk_sys_in, .arst_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_lt_in, .pin_direction_in, .port_latch_in, .cmp_enable_out,
    .cmp_channel_sel_out, .cmp_ref_sel_out, .cmp_pin_override_out, .cmp_pin_data_out,
    .cmp_pin_drive_out);
  ccl_analog_model pm_u (.enable_in(cmp_enable_out), .channel_in(cmp_channel_sel_out),
    .ref_in(cmp_ref_sel_out), .lt_out(cmp_lt_in));
  // Free-running system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // Cuts a hang short well after the longest expected run.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Ready is looked at mid-cycle so that the handshake edge is known before it comes.
  task wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk_sys_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge clk_sys_in);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk("bresp", s_axi_bresp, er);
      @(posedge clk_sys_in);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tr;
    @(posedge clk_sys_in);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge clk_sys_in);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk("rresp", s_axi_rresp, er);
      if (tr && er === OK) chk("rdata", s_axi_rdata, {24'h000000, d});
      @(posedge clk_sys_in);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask : rdc
  // Waits out the result's response time after a selection change.
  task settle;
    repeat (5) @(posedge clk_sys_in);
  endtask : settle
  task results;
    $display("TB: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // Main sequence: reset, register map, every selection code, then pin control.
  initial begin
    arst_n_in = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    {pin_direction_in, port_latch_in} = 4'h0;
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    rdc(ccl_pkg::CCL_ADDR_FIRST_CTRL, 8'h00, OK);
    rdc(ccl_pkg::CCL_ADDR_SECOND_CTRL, 8'h00, OK);
    rdc(AX, 8'h00, OK);
    rdc(4'hC, 8'h00, ERR);
    wr(4'hC, 8'hFF, 4'hF, ERR);
    wr(ccl_pkg::CCL_ADDR_FIRST_CTRL, 8'hFF, 4'hF, OK);
    settle();
    rdc(ccl_pkg::CCL_ADDR_FIRST_CTRL, 8'hF7, OK);
    wr(ccl_pkg::CCL_ADDR_FIRST_CTRL, 8'h00, 4'h0, OK);
    rdc(ccl_pkg::CCL_ADDR_FIRST_CTRL, 8'hF7, OK);
    wr(AX, 8'hFF, 4'hF, OK);
    rdc(AX, 8'hFE, OK);
    wr(AX, 8'h00, 4'hF, OK);
    $display("TB: test map done");
    for (int c = 0; c < 2; c++) begin
      ca = c ? ccl_pkg::CCL_ADDR_SECOND_CTRL : ccl_pkg::CCL_ADDR_FIRST_CTRL;
      for (int k = 0; k < 16; k++) begin
        ctl = {1'b1, 2'b00, k[3], 1'b0, k[2], k[1:0]};
        res = ((k[1:0] * 10) < (k[2] ? 25 : 15)) ^ k[3];
        wr(ca, ctl, 4'hF, OK);
        settle();
        rdc(ca, ctl | {1'b0, res, 6'h00}, OK);
        rdc(AX, {6'h00, c ? 1'b0 : res, c ? res : 1'b0}, OK);
        chk("chsel", cmp_channel_sel_out[c*2+:2], k[1:0]);
        chk("refsel", cmp_ref_sel_out[c], k[2]);
        chk("enable", cmp_enable_out[c], 1'b1);
      end
      wr(ca, 8'hA0, 4'hF, OK);
      settle();
      chk("drive", cmp_pin_drive_out[c], 1'b1);
      chk("pindata", cmp_pin_data_out[c], 1'b1);
      pin_direction_in[c] <= 1'b1;
      settle();
      chk("drive", cmp_pin_drive_out[c], 1'b0);
      pin_direction_in[c] <= 1'b0;
      wr(ca, 8'h20, 4'hF, OK);
      settle();
      rdc(ca, 8'h20, OK);
      chk("drive", cmp_pin_drive_out[c], 1'b0);
      chk("override", cmp_pin_override_out[c], 1'b1);
      chk("pindata", cmp_pin_data_out[c], 1'b0);
      wr(ca, 8'h00, 4'hF, OK);
      port_latch_in[c] <= 1'b1;
      settle();
      chk("override", cmp_pin_override_out[c], 1'b0);
      chk("pindata", cmp_pin_data_out[c], 1'b1);
      port_latch_in[c] <= 1'b0;
      $display("TB: test comparator %0d done", c);
    end
    results();
  end
endmodule : test_comparator_control_logic

// ===== verilog/ccl_cmp_if.sv
`timescale 1ns/100ps
// ==========================================================================
// Signals between the control register file and one comparator slice.
interface ccl_cmp_if;
  logic enable;
  logic pol;
  logic oe;
  logic raw;
  logic result;
  modport ctrl (output enable, output pol, output oe, input result);
  modport slice (input enable, input pol, input oe, output raw, output result);
endinterface : ccl_cmp_if

// ===== verilog/ccl_pkg.sv
package ccl_pkg;
  // ==========================================================================
  // Register map, byte addresses.
  localparam logic [3:0] CCL_ADDR_FIRST_CTRL = 4'h0;
  localparam logic [3:0] CCL_ADDR_SECOND_CTRL = 4'h4;
  localparam logic [3:0] CCL_ADDR_SECOND_AUX = 4'h8;
  // ==========================================================================
  // Control register fields.
  localparam int CCL_BIT_ENABLE = 7;
  localparam int CCL_BIT_RESULT = 6;
  localparam int CCL_BIT_OE = 5;
  localparam int CCL_BIT_POL = 4;
  localparam int CCL_BIT_REF = 2;
  localparam int CCL_BIT_CH_LO = 0;
  localparam logic [7:0] CCL_CTRL_WMASK = 8'hB7;
  localparam logic [7:0] CCL_CTRL_RESET = 8'h00;
  // Auxiliary register: result mirrors in bits 1 and 0, rest writable.
  localparam int CCL_BIT_MIRROR1 = 1;
  localparam int CCL_BIT_MIRROR2 = 0;
  localparam logic [7:0] CCL_AUX_WMASK = 8'hFC;
  localparam logic [7:0] CCL_AUX_RESET = 8'h00;
  localparam logic [1:0] CCL_RESP_OKAY = 2'h0;
  localparam logic [1:0] CCL_RESP_SLVERR = 2'h2;
endpackage : ccl_pkg

// ===== verilog/ccl_slice.sv
`timescale 1ns/100ps
// ==========================================================================
// One comparator slice: polarity and per-cycle latch of the analog decision.
module ccl_slice (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic cmp_lt_in,
  ccl_cmp_if.slice port
);
  logic sync1_q;
  logic sync2_q;
  logic res_q;
  logic res_d;

  // Polarity applied to the synchronised decision; a disabled core reads low.
  always_comb begin
    port.raw = port.enable & (sync2_q ^ port.pol);
    res_d = port.raw;
  end

  // Two flops tame the asynchronous analog decision, then one latch per cycle.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      res_q <= 1'b0;
    end else begin
      sync1_q <= cmp_lt_in;
      sync2_q <= sync1_q;
      res_q <= res_d;
    end
  end

  assign port.result = res_q;
endmodule : ccl_slice

// ===== verilog/ccl_top.sv
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
// ==========================================================================
// Comparator control logic with an AXI4-Lite register slave.
module ccl_top (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cmp_lt_in,
  input wire logic [1:0] pin_direction_in,
  input wire logic [1:0] port_latch_in,
  output logic [1:0] cmp_enable_out,
  output logic [3:0] cmp_channel_sel_out,
  output logic [1:0] cmp_ref_sel_out,
  output logic [1:0] cmp_pin_override_out,
  output logic [1:0] cmp_pin_data_out,
  output logic [1:0] cmp_pin_drive_out
);
  // Register file.
  logic [7:0] ctrl_q [2];
  logic [7:0] ctrl_d [2];
  logic [7:0] aux_q;
  logic [7:0] aux_d;

  // Write channel state.
  logic aw_q;
  logic aw_d;
  logic w_q;
  logic w_d;
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic [3:0] awaddr_q;
  logic [3:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  // Read channel state.
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Pin synchronisers and pin controls.
  logic [1:0] dir_s1_q;
  logic [1:0] dir_s2_q;
  logic [1:0] lat_s1_q;
  logic [1:0] lat_s2_q;
  logic [1:0] ovr_q;
  logic [1:0] ovr_d;
  logic [1:0] pdat_q;
  logic [1:0] pdat_d;
  logic [1:0] drv_q;
  logic [1:0] drv_d;

  // Analog routing next values and the per-comparator decisions.
  logic [1:0] en_d;
  logic [1:0] ref_d;
  logic [3:0] ch_d;
  logic [1:0] result;
  logic [1:0] raw_w;

  // Merge a byte-lane write under the writable mask; read-only bits keep their value.
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic strobe, input logic [7:0] wmask);
    merge_byte = strobe ? ((old_v & ~wmask) | (new_v & wmask)) : old_v;
  endfunction : merge_byte

  // Compose a control register read with the live latched result.
  // A disabled core reads zero, so a cleared enable also clears the status bit.
  function automatic logic [7:0] ctrl_view(input logic [7:0] v, input logic res);
    ctrl_view = v;
    ctrl_view[ccl_pkg::CCL_BIT_RESULT] = res;
  endfunction : ctrl_view

  // ==========================================================================
  // Comparator slices, one per comparator.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      ccl_cmp_if cif ();
      assign cif.enable = ctrl_q[gi][ccl_pkg::CCL_BIT_ENABLE];
      assign cif.pol = ctrl_q[gi][ccl_pkg::CCL_BIT_POL];
      assign cif.oe = ctrl_q[gi][ccl_pkg::CCL_BIT_OE];
      assign result[gi] = cif.result;
      // The unlatched decision feeds the pin path only.
      assign raw_w[gi] = cif.raw;
      ccl_slice u_slice (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .cmp_lt_in(cmp_lt_in[gi]),
        .port(cif.slice)
      );
    end
  endgenerate

  // ==========================================================================
  // Write channel: address and data taken in either order, response after both.
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d[0] = ctrl_q[0];
    ctrl_d[1] = ctrl_q[1];
    aux_d = aux_q;
    if (s_axi_awvalid && awready_q) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    // Both halves held: commit the write and raise the answer.
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ccl_pkg::CCL_RESP_OKAY;
      unique case (awaddr_q)
        ccl_pkg::CCL_ADDR_FIRST_CTRL: begin
          ctrl_d[0] = merge_byte(ctrl_q[0], wdata_q[7:0], wstrb_q[0],
                                 ccl_pkg::CCL_CTRL_WMASK);
        end
        ccl_pkg::CCL_ADDR_SECOND_CTRL: begin
          ctrl_d[1] = merge_byte(ctrl_q[1], wdata_q[7:0], wstrb_q[0],
                                 ccl_pkg::CCL_CTRL_WMASK);
        end
        ccl_pkg::CCL_ADDR_SECOND_AUX: begin
          aux_d = merge_byte(aux_q, wdata_q[7:0], wstrb_q[0], ccl_pkg::CCL_AUX_WMASK);
        end
        default: begin
          bresp_d = ccl_pkg::CCL_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Registered readies cost one idle cycle between writes; in exchange every
    // bus output leaves a flip-flop and no path runs from valid to ready.
    awready_d = !aw_d && !bvalid_d;
    wready_d = !w_d && !bvalid_d;
  end

  // ==========================================================================
  // Read channel: one cycle from address to data.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = ccl_pkg::CCL_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (s_axi_araddr)
        ccl_pkg::CCL_ADDR_FIRST_CTRL: rdata_d[7:0] = ctrl_view(ctrl_q[0], result[0]);
        ccl_pkg::CCL_ADDR_SECOND_CTRL: rdata_d[7:0] = ctrl_view(ctrl_q[1], result[1]);
        ccl_pkg::CCL_ADDR_SECOND_AUX: begin
          rdata_d[7:0] = aux_q;
          rdata_d[ccl_pkg::CCL_BIT_MIRROR1] = result[0];
          rdata_d[ccl_pkg::CCL_BIT_MIRROR2] = result[1];
        end
        default: rresp_d = ccl_pkg::CCL_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // The address slot reopens the cycle after the read data has been taken.
    arready_d = !rvalid_d;
  end

  // ==========================================================================
  // Pin side: the override follows the OE bit alone, drive needs all three.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ovr_d[i] = ctrl_q[i][ccl_pkg::CCL_BIT_OE];
      // The pin carries the polarity-corrected decision, not the cycle latch.
      pdat_d[i] = ovr_d[i] ? raw_w[i] : lat_s2_q[i];
      // Drive needs the direction bit clear too, so an input pin never fights.
      drv_d[i] = ctrl_q[i][ccl_pkg::CCL_BIT_OE] & ~dir_s2_q[i]
                 & ctrl_q[i][ccl_pkg::CCL_BIT_ENABLE];
    end
  end

  // Analog routing selections straight from the control registers.
  // They are registered once more so that the analog side sees clean levels.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      en_d[i] = ctrl_q[i][ccl_pkg::CCL_BIT_ENABLE];
      ref_d[i] = ctrl_q[i][ccl_pkg::CCL_BIT_REF];
      ch_d[2*i +: 2] = ctrl_q[i][ccl_pkg::CCL_BIT_CH_LO +: 2];
    end
  end

  // ==========================================================================
  // State registers.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q[0] <= ccl_pkg::CCL_CTRL_RESET;
      ctrl_q[1] <= ccl_pkg::CCL_CTRL_RESET;
      aux_q <= ccl_pkg::CCL_AUX_RESET;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      // Readies stay low in reset and rise at the first edge after release.
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      // Direction resets to input so no pin is driven before the synchroniser fills.
      dir_s1_q <= 2'h3;
      dir_s2_q <= 2'h3;
      lat_s1_q <= 2'h0;
      lat_s2_q <= 2'h0;
      ovr_q <= 2'h0;
      pdat_q <= 2'h0;
      drv_q <= 2'h0;
      cmp_enable_out <= 2'h0;
      cmp_channel_sel_out <= 4'h0;
      cmp_ref_sel_out <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      aux_q <= aux_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      arready_q <= arready_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      dir_s1_q <= pin_direction_in;
      dir_s2_q <= dir_s1_q;
      lat_s1_q <= port_latch_in;
      lat_s2_q <= lat_s1_q;
      ovr_q <= ovr_d;
      pdat_q <= pdat_d;
      drv_q <= drv_d;
      // Routing outputs follow a control register write by one cycle.
      cmp_enable_out <= en_d;
      cmp_channel_sel_out <= ch_d;
      cmp_ref_sel_out <= ref_d;
    end
  end

  // Bus answers and pin controls leave straight from flip-flops.
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign cmp_pin_override_out = ovr_q;
  assign cmp_pin_data_out = pdat_q;
  assign cmp_pin_drive_out = drv_q;
endmodule : ccl_top
